// ---- design/timed_output_step_sequencer.sv ----
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "seq_defines.svh"
module timed_output_step_sequencer #(
  parameter int TICKS_PER_SEC = `SECOND_NS / `CLK_NS
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [1:0]       chan_on_out,
  output logic [1:0]       running_out
);
  logic              enable [2];
  seq_pkg::term_e    termination_choice [2];
  logic              rep_inf [2];
  logic [16:0]       rep_cnt [2];
  logic [11:0]       steps [2];
  logic [10:0]       start_idx [2];
  logic [9:0]        step_mem [2][2048];
  seq_pkg::seq_state_e st [2];
  logic [10:0]       cur_idx [2];
  logic [11:0]       played [2];
  logic [16:0]       passes [2];
  logic [8:0]        remain [2];
  logic [31:0]       tick [2];
  logic              q_act;
  logic              q_hdr;
  logic              q_ch;
  logic [10:0]       q_idx;
  logic [11:0]       q_left;
  logic [3:0]        q_pos;
  logic [15:0]       q_len;
  logic [7:0]        q_byte;
  logic [9:0]        q_rec;
  logic              req;
  logic              acc;
  logic              wr_ok;
  logic              rd_acc;
  logic              ch;
  logic [3:0]        rsel;
  logic              mapped;
  logic              bad;
  logic [31:0]       next_rdata;
  logic [11:0]       q_cnt;

  function automatic logic [7:0] dig(input logic [15:0] v,
                                     input logic [3:0] p);
    logic [15:0] pw;
    pw = 16'h0001;
    case (p)
      4'h1: pw = 16'h000A;
      4'h2: pw = 16'h0064;
      4'h3: pw = 16'h03E8;
      4'h4: pw = 16'h2710;
      default: pw = 16'h0001;
    endcase
    // Lengths stay below 100000, upper header digits are zero
    if (p > 4'h4)
      dig = 8'h30;
    else
      dig = 8'h30 + 8'((v / pw) % 16'h000A);
  endfunction

  assign req    = psel_in & penable_in & ~pready_out;
  assign acc    = psel_in & penable_in & pready_out;
  assign ch     = paddr_in[`CH_ADDR_BIT];
  assign rsel   = paddr_in[5:2];
  assign mapped = (paddr_in[11:7] == 5'h00) && (paddr_in[1:0] == 2'h0)
                  && (rsel <= `OFS_POS);
  assign q_cnt  = (pwdata_in[27:16] == 12'h000) ? 12'h001
                  : pwdata_in[27:16];

  always_comb
  begin
    bad = ~mapped;
    if (pwrite_in && mapped)
    begin
      case (rsel)
        `OFS_CTRL:
          bad = (pwdata_in[2:1] == 2'b11);
        `OFS_REPEAT:
          bad = ~pwdata_in[`REP_INF_BIT] && ((pwdata_in[16:0] == 17'h0)
                || (pwdata_in[16:0] > `MAX_REPEAT));
        `OFS_STEPS:
          bad = (pwdata_in[11:0] == 12'h000)
                || (pwdata_in[11:0] > `MAX_STEPS)
                || (pwdata_in[15:12] != 4'h0);
        `OFS_START:
          bad = (pwdata_in[15:11] != 5'h00);
        `OFS_STEP_WR:
          bad = (pwdata_in[24:16] == 9'h000)
                || (pwdata_in[24:16] > `MAX_DUR);
        `OFS_QUERY:
          bad = (q_cnt > `MAX_STEPS);
        `OFS_RDBYTE,
        `OFS_POS:
          bad = 1'b1;
        default:
          bad = 1'b1;
      endcase
    end
  end

  assign wr_ok  = acc & pwrite_in & ~bad;
  assign rd_acc = acc & ~pwrite_in & mapped;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (rsel)
      `OFS_CTRL:
        next_rdata = {14'h0, chan_on_out[ch], running_out[ch], 7'h0,
                      1'b0, 5'h0, termination_choice[ch], enable[ch]};
      `OFS_REPEAT:
        next_rdata = rep_inf[ch] ? 32'h8000_0000 : {15'h0, rep_cnt[ch]};
      `OFS_STEPS:
        next_rdata = {20'h0, steps[ch]};
      `OFS_START:
        next_rdata = {21'h0, start_idx[ch]};
      `OFS_QUERY:
        next_rdata = {15'h0, passes[ch]};
      `OFS_RDBYTE:
        next_rdata = {23'h0, q_act && (q_ch == ch), q_byte};
      `OFS_POS:
        next_rdata = {7'h0, remain[ch], 5'h0, cur_idx[ch]};
      default:
        next_rdata = 32'h0000_0000;
    endcase
    if (!mapped)
      next_rdata = 32'h0000_0000;
  end

  // Fixed one wait state keeps decode and range checks off the bus path
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out <= req;
      if (req)
      begin
        pslverr_out <= bad;
        prdata_out  <= pwrite_in ? 32'h0000_0000 : next_rdata;
      end
      else
      begin
        pslverr_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int c = 0; c < 2; c++)
      begin
        termination_choice[c] <= seq_pkg::TERM_OFF;
        rep_inf[c]            <= 1'b0;
        rep_cnt[c]            <= `RST_REPEAT;
        steps[c]              <= `RST_STEPS;
        start_idx[c]          <= 11'h000;
      end
    end
    else if (wr_ok)
    begin
      case (rsel)
        `OFS_CTRL:
          termination_choice[ch] <= seq_pkg::term_e'(pwdata_in[2:1]);
        `OFS_REPEAT:
        begin
          rep_inf[ch] <= pwdata_in[`REP_INF_BIT];
          if (!pwdata_in[`REP_INF_BIT])
            rep_cnt[ch] <= pwdata_in[16:0];
        end
        `OFS_STEPS:
          steps[ch] <= pwdata_in[11:0];
        `OFS_START:
          start_idx[ch] <= pwdata_in[10:0];
        default:
        begin
        end
      endcase
    end
  end

  // Step table has no reset; contents are undefined until written
  always_ff @(posedge ref_clk_in)
  begin
    if (wr_ok && (rsel == `OFS_STEP_WR))
      step_mem[ch][pwdata_in[10:0]] <= {pwdata_in[`STEP_ST_BIT],
                                        pwdata_in[24:16]};
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int c = 0; c < 2; c++)
      begin
        enable[c]      <= 1'b0;
        st[c]          <= seq_pkg::ST_IDLE;
        cur_idx[c]     <= 11'h000;
        played[c]      <= 12'h000;
        passes[c]      <= 17'h00000;
        remain[c]      <= 9'h000;
        tick[c]        <= 32'h0000_0000;
        chan_on_out[c] <= 1'b0;
        running_out[c] <= 1'b0;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wr_ok && (rsel == `OFS_CTRL) && (ch == 1'(c)))
        begin
          enable[c] <= pwdata_in[`CTRL_EN_BIT];
          // Rising enable or restart both reload from the start step
          if (pwdata_in[`CTRL_EN_BIT] &&
              (!enable[c] || pwdata_in[`CTRL_RESTART]))
          begin
            st[c]          <= seq_pkg::ST_RUN;
            cur_idx[c]     <= start_idx[c];
            played[c]      <= 12'h000;
            passes[c]      <= 17'h00000;
            remain[c]      <= step_mem[c][start_idx[c]][8:0];
            tick[c]        <= 32'h0000_0000;
            chan_on_out[c] <= step_mem[c][start_idx[c]][9];
            running_out[c] <= 1'b1;
          end
          else if (!pwdata_in[`CTRL_EN_BIT])
          begin
            st[c]          <= seq_pkg::ST_IDLE;
            chan_on_out[c] <= 1'b0;
            running_out[c] <= 1'b0;
          end
        end
        else
        begin
          case (st[c])
            seq_pkg::ST_RUN:
            begin
              if (tick[c] == 32'(TICKS_PER_SEC - 1))
              begin
                tick[c] <= 32'h0000_0000;
                if (remain[c] > 9'h001)
                  remain[c] <= remain[c] - 9'h001;
                else if (played[c] + 12'h001 < steps[c])
                begin
                  cur_idx[c]     <= cur_idx[c] + 11'h001;
                  played[c]      <= played[c] + 12'h001;
                  remain[c]      <= step_mem[c][cur_idx[c] + 11'h001][8:0];
                  chan_on_out[c] <= step_mem[c][cur_idx[c] + 11'h001][9];
                end
                else if (!rep_inf[c] && (passes[c] + 17'h1 >= rep_cnt[c]))
                begin
                  passes[c]      <= passes[c] + 17'h1;
                  st[c]          <= seq_pkg::ST_DONE;
                  running_out[c] <= 1'b0;
                  case (termination_choice[c])
                    seq_pkg::TERM_ON:   chan_on_out[c] <= 1'b1;
                    seq_pkg::TERM_OFF:  chan_on_out[c] <= 1'b0;
                    default:            chan_on_out[c] <= chan_on_out[c];
                  endcase
                end
                else
                begin
                  // Unlimited repeat lets the pass counter saturate
                  if (passes[c] != `MAX_REPEAT)
                    passes[c] <= passes[c] + 17'h1;
                  cur_idx[c]     <= start_idx[c];
                  played[c]      <= 12'h000;
                  remain[c]      <= step_mem[c][start_idx[c]][8:0];
                  chan_on_out[c] <= step_mem[c][start_idx[c]][9];
                end
              end
              else
              begin
                tick[c] <= tick[c] + 32'h0000_0001;
              end
            end
            seq_pkg::ST_IDLE,
            seq_pkg::ST_DONE:
            begin
              tick[c] <= 32'h0000_0000;
            end
            default:
            begin
              st[c] <= seq_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  assign q_rec = step_mem[q_ch][q_idx];

  always_comb
  begin
    q_byte = 8'h00;
    if (q_hdr)
    begin
      case (q_pos)
        4'h0:    q_byte = 8'h23;
        4'h1:    q_byte = `HDR_DIGITS;
        default: q_byte = dig(q_len, 4'hA - q_pos);
      endcase
    end
    else
    begin
      case (q_pos)
        4'h0, 4'h1, 4'h2, 4'h3:
          q_byte = dig({5'h00, q_idx}, 4'h3 - q_pos);
        4'h4, 4'h6:
          q_byte = 8'h2C;
        4'h5:
          q_byte = q_rec[9] ? 8'h31 : 8'h30;
        4'h7, 4'h8, 4'h9:
          q_byte = dig({7'h00, q_rec[8:0]}, 4'h9 - q_pos);
        default:
          q_byte = 8'h3B;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      q_act  <= 1'b0;
      q_hdr  <= 1'b0;
      q_ch   <= 1'b0;
      q_idx  <= 11'h000;
      q_left <= 12'h000;
      q_pos  <= 4'h0;
      q_len  <= 16'h0000;
    end
    else if (wr_ok && (rsel == `OFS_QUERY))
    begin
      q_act  <= 1'b1;
      q_hdr  <= 1'b1;
      q_ch   <= ch;
      q_idx  <= pwdata_in[10:0];
      q_left <= q_cnt;
      q_pos  <= 4'h0;
      // Widened before the product, 2048 records need 15 bits
      q_len  <= 16'(q_cnt) * 16'(`REC_BYTES);
    end
    else if (rd_acc && (rsel == `OFS_RDBYTE) && q_act && (q_ch == ch))
    begin
      if (q_pos == `HDR_BYTES - 4'h1)
      begin
        q_pos <= 4'h0;
        if (q_hdr)
          q_hdr <= 1'b0;
        else
        begin
          q_idx  <= q_idx + 11'h001;
          q_left <= q_left - 12'h001;
          if (q_left == 12'h001)
            q_act <= 1'b0;
        end
      end
      else
      begin
        q_pos <= q_pos + 4'h1;
      end
    end
  end

  a_pready_wait: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready not given one cycle after access");
  a_pready_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  a_steps_bounded: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    steps[0] >= 12'h001 && steps[0] <= `MAX_STEPS)
    else $error("step count out of range");
  a_bad_steps_kept: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    acc && pwrite_in && rsel == `OFS_STEPS && !ch && bad
    |=> $stable(steps[0]))
    else $error("refused step count changed setting");
  a_term_off_out: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(st[0] == seq_pkg::ST_DONE) && termination_choice[0] ==
    seq_pkg::TERM_OFF |-> !chan_on_out[0])
    else $error("termination off left output on");
  a_term_on_out: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(st[0] == seq_pkg::ST_DONE) && termination_choice[0] ==
    seq_pkg::TERM_ON |-> chan_on_out[0])
    else $error("termination on left output off");
  a_restart_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_ok && rsel == `OFS_CTRL && !ch && pwdata_in[0] && pwdata_in[8]
    |=> cur_idx[0] == $past(start_idx[0]) && running_out[0])
    else $error("restart did not reload start step");
  a_disable_stops: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_ok && rsel == `OFS_CTRL && !ch && !pwdata_in[0]
    |=> st[0] == seq_pkg::ST_IDLE ##1 !running_out[0])
    else $error("disable did not stop channel");
  a_hdr_hash: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_ok && rsel == `OFS_QUERY |=> q_hdr && q_byte == 8'h23)
    else $error("read-back does not open with hash");
  a_run_needs_en: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    running_out[0] |-> enable[0])
    else $error("channel runs while disabled");

  c_done_reached: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(st[0] == seq_pkg::ST_DONE));
  c_query_ends: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $fell(q_act));
  c_step_wrap: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st[0] == seq_pkg::ST_RUN && $changed(passes[0]));
endmodule
`default_nettype wire

// ---- pkg/seq_defines.svh ----
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
// Behaviour
// - A repeat read returns the infinite marker alone or the finite marker with the count.
// - At sequence end the output goes on, off, or stays at the last step state.
// - The active step count is accepted from 1 to 2048 and only that many steps play.
// - A step count read returns the configured count of the addressed channel.
// - Steps are stored at index 0 to 2047 by a write carrying index, state and duration.
// - Each step holds an on/off state and a duration of 1 to 300 seconds.
// - A read-back query takes a start index and optional count and returns those steps.
// - Read-back data opens with a hash, a digit count, then the payload byte count.
// - Each record is index, state, duration separated by commas and ends in a semicolon.
// - Restart plays the channel again from its start step whatever the position.
// - The start step index 0 to 2047 is accepted and can be read back.
// - Every setting and command exists separately for each of the two channels; the code shares one read-back query between them.
// - Repeat is unlimited or a finite pass count of 1 to 99999.
// - The sequencer runs only while the channel enable is set.

`define OFS_CTRL       4'h0
`define OFS_REPEAT     4'h1
`define OFS_STEPS      4'h2
`define OFS_START      4'h3
`define OFS_STEP_WR    4'h4
`define OFS_QUERY      4'h5
`define OFS_RDBYTE     4'h6
`define OFS_POS        4'h7
`define CH_ADDR_BIT    6
`define CTRL_EN_BIT    0
`define CTRL_TERM_LSB  1
`define CTRL_RESTART   8
`define CTRL_RUN_BIT   16
`define CTRL_OUT_BIT   17
`define REP_INF_BIT    31
`define STEP_ST_BIT    11
`define DUR_LSB        16
`define QCNT_LSB       16
`define MAX_STEPS      12'h800
`define MAX_DUR        9'h12C
`define MAX_REPEAT     17'h1869F
`define RST_STEPS      12'h001
`define RST_REPEAT     17'h00001
`define REC_BYTES      4'hB
`define HDR_BYTES      4'hB
`define HDR_DIGITS     8'h39
`define SECOND_NS      1000000000
`define CLK_NS         50
`endif

// ---- pkg/seq_pkg.sv ----
`default_nettype none
package seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } seq_state_e;
  typedef enum logic [1:0] {
    TERM_OFF  = 2'b00,
    TERM_ON   = 2'b01,
    TERM_LAST = 2'b10
  } term_e;
endpackage
`default_nettype wire

// ---- verification/apb_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module apb_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out
);
  initial
  begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'h000;
    pwdata_out  = 32'h00000000;
  end

  // Request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err, output logic ok);
    int n;
    ok = 1'b0;
    err = 1'b0;
    rdata = 32'h00000000;
    @(posedge clk_in);
    psel_out   <= 1'b1;
    pwrite_out <= wr;
    paddr_out  <= addr;
    pwdata_out <= wdata;
    @(posedge clk_in);
    penable_out <= 1'b1;
    for (n = 0; n < 16 && !ok; n++)
    begin
      @(posedge clk_in);
      if (pready_in === 1'b1)
      begin
        ok = 1'b1;
        rdata = prdata_in;
        err = pslverr_in;
      end
    end
    // Released at the very edge that took the answer
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_timed_output_step_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "seq_defines.svh"
module tb_timed_output_step_sequencer;
  localparam int TPS = 4;
  logic        ref_clk_in;
  logic        rst_n_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  chan_on;
  logic [1:0]  running;
  int          num_errors;
  int          samples_checked;

  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  apb_host_model host_u (
    .clk_in      (ref_clk_in),
    .prdata_in   (prdata),
    .pready_in   (pready),
    .pslverr_in  (pslverr),
    .psel_out    (psel),
    .penable_out (penable),
    .pwrite_out  (pwrite),
    .paddr_out   (paddr),
    .pwdata_out  (pwdata)
  );

  timed_output_step_sequencer #(.TICKS_PER_SEC(TPS)) dut_u (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .psel_in     (psel),
    .penable_in  (penable),
    .pwrite_in   (pwrite),
    .paddr_in    (paddr),
    .pwdata_in   (pwdata),
    .prdata_out  (prdata),
    .pready_out  (pready),
    .pslverr_out (pslverr),
    .chan_on_out (chan_on),
    .running_out (running)
  );

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic ch, input logic [3:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    logic ok;
    host_u.xfer(w, {5'h00, ch, ofs, 2'b00}, wd, rd, err, ok);
    if (!ok)
    begin
      num_errors++;
      $display("[FAIL] bus answer expected 1 seen 0");
      finish_test();
    end
  endtask

  task automatic wr(input logic ch, input logic [3:0] ofs,
                    input logic [31:0] wd, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    bus(1'b1, ch, ofs, wd, rd, err);
    check("write error", {31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic rd(input logic ch, input logic [3:0] ofs,
                    input logic [31:0] exp, input logic exp_err);
    logic [31:0] data;
    logic        err;
    bus(1'b0, ch, ofs, 32'h00000000, data, err);
    check("read data", data, exp);
    check("read error", {31'h0, err}, {31'h0, exp_err});
  endtask

  task automatic t_reset();
    rd(1'b0, `OFS_CTRL, 32'h00000000, 1'b0);
    rd(1'b0, `OFS_REPEAT, 32'h00000001, 1'b0);
    rd(1'b0, `OFS_STEPS, 32'h00000001, 1'b0);
    rd(1'b0, `OFS_START, 32'h00000000, 1'b0);
    rd(1'b0, 4'h8, 32'h00000000, 1'b1);
  endtask

  task automatic t_config();
    wr(1'b0, `OFS_REPEAT, 32'h80000000, 1'b0);
    rd(1'b0, `OFS_REPEAT, 32'h80000000, 1'b0);
    wr(1'b0, `OFS_REPEAT, 32'h00000064, 1'b0);
    rd(1'b0, `OFS_REPEAT, 32'h00000064, 1'b0);
    wr(1'b0, `OFS_REPEAT, 32'h00000000, 1'b1);
    wr(1'b0, `OFS_REPEAT, 32'h0001869F, 1'b0);
    wr(1'b0, `OFS_REPEAT, 32'h000186A0, 1'b1);
    rd(1'b0, `OFS_REPEAT, 32'h0001869F, 1'b0);
    wr(1'b0, `OFS_STEPS, 32'h00000800, 1'b0);
    wr(1'b0, `OFS_STEPS, 32'h00000801, 1'b1);
    wr(1'b0, `OFS_STEPS, 32'h00000000, 1'b1);
    rd(1'b0, `OFS_STEPS, 32'h00000800, 1'b0);
    wr(1'b0, `OFS_START, 32'h000007FF, 1'b0);
    rd(1'b0, `OFS_START, 32'h000007FF, 1'b0);
    rd(1'b1, `OFS_REPEAT, 32'h00000001, 1'b0);
    rd(1'b1, `OFS_STEPS, 32'h00000001, 1'b0);
    rd(1'b1, `OFS_START, 32'h00000000, 1'b0);
  endtask

  task automatic t_readback();
    string s;
    int    i;
    s = "#90000000220005,1,300;0006,0,001;";
    wr(1'b0, `OFS_STEP_WR, 32'h012C0805, 1'b0);
    wr(1'b0, `OFS_STEP_WR, 32'h00010006, 1'b0);
    wr(1'b0, `OFS_STEP_WR, 32'h012D0805, 1'b1);
    wr(1'b0, `OFS_STEP_WR, 32'h00000805, 1'b1);
    wr(1'b0, `OFS_QUERY, 32'h00020005, 1'b0);
    for (i = 0; i < s.len(); i++)
      rd(1'b0, `OFS_RDBYTE, {23'h0, 1'b1, s[i]}, 1'b0);
  endtask

  // Run length is counted in negedges while running is high
  task automatic t_run(input logic [10:0] start, input logic [11:0] steps,
                       input logic [16:0] reps, input logic [1:0] term,
                       input int exp_len, input logic first,
                       input logic last);
    int n;
    wr(1'b0, `OFS_START, {21'h0, start}, 1'b0);
    wr(1'b0, `OFS_STEPS, {20'h0, steps}, 1'b0);
    wr(1'b0, `OFS_REPEAT, {15'h0, reps}, 1'b0);
    wr(1'b0, `OFS_CTRL, {29'h0, term, 1'b1}, 1'b0);
    for (n = 0; n < 8 && running[0] !== 1'b1; n++)
      @(negedge ref_clk_in);
    check("first state", {31'h0, chan_on[0]}, {31'h0, first});
    for (n = 0; n < 4000 && running[0] === 1'b1; n++)
      @(negedge ref_clk_in);
    check("run length", n, exp_len);
    check("end state", {31'h0, chan_on[0]}, {31'h0, last});
    check("other channel", {31'h0, running[1]}, 32'h0);
    wr(1'b0, `OFS_CTRL, 32'h00000000, 1'b0);
    @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    check("disabled", {30'h0, running[0], chan_on[0]}, 32'h0);
  endtask

  task automatic t_restart();
    int n;
    wr(1'b0, `OFS_START, 32'h00000007, 1'b0);
    wr(1'b0, `OFS_STEPS, 32'h00000002, 1'b0);
    wr(1'b0, `OFS_REPEAT, 32'h80000000, 1'b0);
    wr(1'b0, `OFS_CTRL, 32'h00000001, 1'b0);
    for (n = 0; n < 3 * TPS; n++)
      @(negedge ref_clk_in);
    check("second step", {31'h0, chan_on[0]}, 32'h0);
    wr(1'b0, `OFS_CTRL, 32'h00000101, 1'b0);
    @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    check("restarted", {30'h0, running[0], chan_on[0]}, 32'h3);
    wr(1'b0, `OFS_CTRL, 32'h00000000, 1'b0);
    @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    check("stopped", {30'h0, running[0], chan_on[0]}, 32'h0);
  endtask

  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rst_n_in = 1'b0;
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_config();
    t_readback();
    // Short steps keep the run brief: 7 on 2 s, 8 off 1 s, 9 on 1 s
    wr(1'b0, `OFS_STEP_WR, 32'h00020807, 1'b0);
    wr(1'b0, `OFS_STEP_WR, 32'h00010008, 1'b0);
    wr(1'b0, `OFS_STEP_WR, 32'h00010809, 1'b0);
    t_run(11'h007, 12'h002, 17'h00002, seq_pkg::TERM_ON, 6 * TPS, 1'b1, 1'b1);
    t_run(11'h007, 12'h002, 17'h00001, seq_pkg::TERM_OFF, 3 * TPS, 1'b1, 1'b0);
    t_run(11'h008, 12'h002, 17'h00001, seq_pkg::TERM_LAST, 2 * TPS, 1'b0, 1'b1);
    t_restart();
    finish_test();
  end
endmodule
`default_nettype wire
